/* File: src/scg_ctrl.sv */
// switching clock generator control with role select, watchdog and axi regs
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE_01] sample resistor band once when bias ready rises, drive compensation
// [RULE_02] slave band selects expected sync frequency window, seven bands
// [RULE_03] out-of-range resistor code sets resistor error bit 4 of status a
// [RULE_04] master or alone: oscillator period follows resistor band
// [RULE_05] master role drives oscillator clock on the sync pin
// [RULE_06] alone role keeps sync pin undriven and unused
// [RULE_07] sync pin is two-way: output in master, input in slave
// [RULE_08] slave role aligns switching clock to external sync clock
// [RULE_09] slave follows only rising or only falling sync edge; switch_clk copies the sync level, inverted for falling, so it follows the other edge too
// [RULE_10] edge polarity fixed by address strap, never by register
// [RULE_11] slave watchdog measures sync period against band window
// [RULE_12] sync out of window sets watchdog error bit 5 of status a
// [RULE_13] watchdog error marks too high or too low in status c
// [RULE_14] fault mode low: stop switching one hiccup period, then retry
// [RULE_15] fault mode high: first watchdog error latches regulator off
// [RULE_16] address strap selects exactly one role per option
// [RULE_17] bias ready rises only when bias and serial blocks ready
// [RULE_18] band code comes from front end, stable until next rise
// [RULE_19] hiccup wait is a parameter counted in control clock cycles
module scg_ctrl
  import scg_pkg::*;
#(
  parameter int HICCUP_CYCLES = HICCUP_CYCLES_DEF
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bias_ready_flag,
  input wire logic [BAND_W-1:0] resistor_pin_a_band_code,
  input wire logic [1:0] addr_strap,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe_n,
  output logic switch_clk,
  output logic switch_en,
  output logic main_latch_off,
  output logic [BAND_W-1:0] comp_band
);

  // refuse a hiccup period that the wait counter cannot serve
  if (HICCUP_CYCLES < 1)
  begin : g_bad_hiccup
    $error("hiccup period must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and strap capture

  logic bias_s;
  logic sync_s;
  logic [1:0] strap_s;
  logic [BAND_W-1:0] band_s;
  logic bias_d_ff;
  logic sync_d_ff;
  logic bias_rise;
  logic strap_done_ff;
  logic [1:0] strap_cnt_ff;
  logic pol_fall_ff;
  scg_role_e role_ff;

  // band code rides with bias ready, so both arrive with the same latency
  scg_sync #(.WIDTH(4 + BAND_W)) u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({bias_ready_flag, sync_in, addr_strap, resistor_pin_a_band_code}),
    .sync_out({bias_s, sync_s, strap_s, band_s})
  );

  // delayed copies for edge finding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bias_d_ff <= 1'b0;
      sync_d_ff <= 1'b0;
    end
    else
    begin
      bias_d_ff <= bias_s;
      sync_d_ff <= sync_s;
    end
  end

  assign bias_rise = bias_s & ~bias_d_ff; // [RULE_17]

  // strap caught once after reset release, once synchronisers settle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      role_ff <= ROLE_ALONE;
      pol_fall_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == STRAP_SETTLE)
      begin
        strap_done_ff <= 1'b1;
        // 0 alone, 1 master, 2 slave rising, 3 slave falling
        case (strap_s) // [RULE_16]
          2'h0: role_ff <= ROLE_ALONE;
          2'h1: role_ff <= ROLE_MASTER;
          default: role_ff <= ROLE_SLAVE;
        endcase
        pol_fall_ff <= (strap_s == 2'h3); // [RULE_10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resistor band capture

  logic [BAND_W-1:0] band_ff;
  logic band_ok_ff;
  logic res_err_evt;

  // front end holds the code stable, so one sample at the edge suffices
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      band_ff <= '0;
      band_ok_ff <= 1'b0;
    end
    else if (bias_rise)
    begin
      band_ff <= band_s; // [RULE_01] [RULE_18]
      band_ok_ff <= (band_s < BAND_W'(BAND_NUM));
    end
  end

  assign res_err_evt = bias_rise & (band_s >= BAND_W'(BAND_NUM));
  assign comp_band = band_ff; // [RULE_01]

  ////////////////////////////////////////////////////////////////////////////
  // oscillator for alone and master roles

  logic [15:0] osc_cnt_ff;
  logic osc_clk_ff;
  logic [15:0] half_sel;
  logic [15:0] wmin_sel;
  logic [15:0] wmax_sel;

  // band tables unrolled by the case inside the functions
  always_comb
  begin
    half_sel = osc_half(int'(band_ff));
    wmin_sel = wdt_min(int'(band_ff));
    wmax_sel = wdt_max(int'(band_ff));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || role_ff == ROLE_SLAVE || !band_ok_ff)
    begin
      osc_cnt_ff <= 16'h0000;
      osc_clk_ff <= 1'b0;
    end
    else if (osc_cnt_ff >= half_sel - 16'h0001) // [RULE_04]
    begin
      osc_cnt_ff <= 16'h0000;
      osc_clk_ff <= ~osc_clk_ff;
    end
    else
      osc_cnt_ff <= osc_cnt_ff + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync pin and switching clock

  logic follow_edge;
  logic slave_on;

  assign slave_on = strap_done_ff & (role_ff == ROLE_SLAVE);
  // only one edge counts for the watchdog; switch_clk still follows the other edge too
  assign follow_edge = slave_on &
    (pol_fall_ff ? (~sync_s & sync_d_ff) : (sync_s & ~sync_d_ff)); // [RULE_09]

  // pin driven only by a master; alone and slave leave it released
  assign sync_oe_n = ~(strap_done_ff & (role_ff == ROLE_MASTER)); // [RULE_07]
  assign sync_out = ~sync_oe_n & osc_clk_ff; // [RULE_05] [RULE_06]

  // slave output rises one cycle after the followed edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      switch_clk <= 1'b0;
    else if (slave_on)
      switch_clk <= pol_fall_ff ? ~sync_s : sync_s; // [RULE_08]
    else
      switch_clk <= osc_clk_ff; // [RULE_06]
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync watchdog

  logic [15:0] wdt_cnt_ff;
  logic wdt_armed_ff;
  logic wdt_active;
  logic wdt_err_evt;
  logic wdt_high;
  scg_prot_e prot_ff;

  assign wdt_active = slave_on & band_ok_ff & bias_s & (prot_ff == PR_RUN);
  // too fast: edge before the minimum; too slow: edge late or missing
  assign wdt_high = follow_edge & wdt_armed_ff & (wdt_cnt_ff < wmin_sel);
  assign wdt_err_evt = wdt_active & (wdt_high |
    (wdt_armed_ff & (wdt_cnt_ff > wmax_sel))); // [RULE_11] [RULE_02]

  // first edge after arming only starts the measurement
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !wdt_active || wdt_err_evt)
    begin
      wdt_cnt_ff <= 16'h0000;
      wdt_armed_ff <= 1'b0;
    end
    else if (follow_edge)
    begin
      wdt_cnt_ff <= 16'h0001;
      wdt_armed_ff <= 1'b1;
    end
    else if (wdt_armed_ff)
      wdt_cnt_ff <= wdt_cnt_ff + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // hiccup and latch-off protection

  localparam int HW = $clog2(HICCUP_CYCLES + 1);
  logic [HW-1:0] hic_cnt_ff;
  logic [7:0] cfg_ff;

  // latch-off stays until bias ready drops, i.e. a fresh start
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !bias_s)
    begin
      prot_ff <= PR_RUN;
      hic_cnt_ff <= '0;
    end
    else
    begin
      case (prot_ff)
        PR_RUN:
        begin
          hic_cnt_ff <= '0;
          if (wdt_err_evt)
            prot_ff <= cfg_ff[CFG_FAULT_MODE_BIT] ? PR_LATCH : PR_WAIT;
        end // [RULE_14] [RULE_15]
        PR_WAIT:
        begin
          if (hic_cnt_ff == HW'(HICCUP_CYCLES - 1)) // [RULE_19]
            prot_ff <= PR_RUN;
          else
            hic_cnt_ff <= hic_cnt_ff + HW'(1);
        end
        PR_LATCH: prot_ff <= PR_LATCH; // [RULE_15]
        default: prot_ff <= PR_RUN;
      endcase
    end
  end

  // switching also held off on a bad resistor band
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      switch_en <= 1'b0;
      main_latch_off <= 1'b0;
    end
    else
    begin
      // stale band verdict must not enable switching at a fresh bias rise
      switch_en <= strap_done_ff & bias_s & band_ok_ff & ~bias_rise &
        (prot_ff == PR_RUN) & ~wdt_err_evt; // [RULE_14]
      main_latch_off <= (prot_ff == PR_LATCH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic [7:0] fault_a_ff;
  logic [7:0] fault_c_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [5:0] aw_idx_ff;
  logic [7:0] w_byte_ff;
  logic w_lane0_ff;
  logic do_write;
  logic [5:0] ar_idx;

  assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_ff & ~s_axi_bvalid;
  assign do_write = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_idx = s_axi_araddr[7:2];

  // address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 6'h00;
      w_byte_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        w_byte_ff <= s_axi_wdata[7:0];
        w_lane0_ff <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_idx_ff == IDX_FAULT_A || aw_idx_ff == IDX_FAULT_C
          || aw_idx_ff == IDX_MAIN_CFG || aw_idx_ff == IDX_CLK_STAT)
          ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // config register steers the fault reaction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_ff <= CFG_RESET;
    else if (do_write && w_lane0_ff && aw_idx_ff == IDX_MAIN_CFG)
      cfg_ff <= w_byte_ff;
  end

  // sticky faults: write one to clear, a new event wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_a_ff <= FAULT_RESET;
      fault_c_ff <= FAULT_RESET;
    end
    else
    begin
      if (do_write && w_lane0_ff && aw_idx_ff == IDX_FAULT_A)
        fault_a_ff <= fault_a_ff & ~w_byte_ff;
      if (do_write && w_lane0_ff && aw_idx_ff == IDX_FAULT_C)
        fault_c_ff <= fault_c_ff & ~w_byte_ff;
      if (res_err_evt)
        fault_a_ff[FA_RES_ERR_BIT] <= 1'b1; // [RULE_03]
      if (wdt_err_evt)
      begin
        fault_a_ff[FA_WDT_ERR_BIT] <= 1'b1; // [RULE_12]
        if (wdt_high)
          fault_c_ff[FC_HIGH_BIT] <= 1'b1; // [RULE_13]
        else
          fault_c_ff[FC_LOW_BIT] <= 1'b1; // [RULE_13]
      end
    end
  end

  // read data registered; unmapped reads answer slverr and zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (ar_idx)
        IDX_FAULT_A: s_axi_rdata <= {24'h000000, fault_a_ff};
        IDX_FAULT_C: s_axi_rdata <= {24'h000000, fault_c_ff};
        IDX_MAIN_CFG: s_axi_rdata <= {24'h000000, cfg_ff};
        IDX_CLK_STAT: s_axi_rdata <= {16'h0000, main_latch_off, switch_en,
          prot_ff, pol_fall_ff, role_ff, band_ok_ff, band_ff, 4'h0};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_band_sample;
    @(posedge aclk) disable iff (!aresetn)
    bias_rise |=> (band_ff == $past(band_s)) ##1 $stable(band_ff);
  endproperty
  a_band_sample: assert property (p_band_sample) // [RULE_01]
    else $error("band not sampled at bias ready rise");

  property p_res_err;
    @(posedge aclk) disable iff (!aresetn)
    res_err_evt |=> fault_a_ff[FA_RES_ERR_BIT] && !band_ok_ff && !switch_en;
  endproperty
  a_res_err: assert property (p_res_err) // [RULE_03]
    else $error("resistor error not flagged");

  property p_pin_role;
    @(posedge aclk) disable iff (!aresetn)
    strap_done_ff |-> (sync_oe_n == (role_ff != ROLE_MASTER));
  endproperty
  a_pin_role: assert property (p_pin_role) // [RULE_07]
    else $error("sync pin drive does not match role");

  property p_alone_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (role_ff == ROLE_ALONE) |-> sync_oe_n && !sync_out;
  endproperty
  a_alone_quiet: assert property (p_alone_quiet) // [RULE_06]
    else $error("stand-alone role touches sync pin");

  sequence s_followed;
    follow_edge;
  endsequence
  property p_follow;
    @(posedge aclk) disable iff (!aresetn)
    s_followed |=> $rose(switch_clk);
  endproperty
  a_follow: assert property (p_follow) // [RULE_09]
    else $error("switching clock missed the followed sync edge");

  property p_pol_fixed;
    @(posedge aclk) disable iff (!aresetn)
    strap_done_ff |=> $stable(pol_fall_ff) && $stable(role_ff);
  endproperty
  a_pol_fixed: assert property (p_pol_fixed) // [RULE_10]
    else $error("strap derived setting changed");

  property p_wdt_flags;
    @(posedge aclk) disable iff (!aresetn)
    wdt_err_evt |=> fault_a_ff[FA_WDT_ERR_BIT] &&
      (fault_c_ff[FC_HIGH_BIT] || fault_c_ff[FC_LOW_BIT]);
  endproperty
  a_wdt_flags: assert property (p_wdt_flags) // [RULE_12]
    else $error("watchdog error flags not set");

  sequence s_hic_start;
    wdt_err_evt && !cfg_ff[CFG_FAULT_MODE_BIT] && bias_s;
  endsequence
  property p_hiccup;
    @(posedge aclk) disable iff (!aresetn)
    s_hic_start |=> (prot_ff == PR_WAIT) ##1 !switch_en;
  endproperty
  a_hiccup: assert property (p_hiccup) // [RULE_14]
    else $error("hiccup wait not entered");

  property p_latch;
    @(posedge aclk) disable iff (!aresetn)
    wdt_err_evt && cfg_ff[CFG_FAULT_MODE_BIT] && bias_s
      |=> (prot_ff == PR_LATCH) ##1 main_latch_off;
  endproperty
  a_latch: assert property (p_latch) // [RULE_15]
    else $error("latch-off not taken");

  property p_hic_end;
    @(posedge aclk) disable iff (!aresetn)
    (prot_ff == PR_WAIT) && bias_s && (hic_cnt_ff == HW'(HICCUP_CYCLES - 1))
      |=> (prot_ff == PR_RUN);
  endproperty
  a_hic_end: assert property (p_hic_end) // [RULE_19]
    else $error("hiccup wait did not end on count");

endmodule
`default_nettype wire

/* File: src/scg_pkg.sv */
// package: constants and types for the switching clock generator control
package scg_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_FAULT_A = 6'h01;
  localparam logic [5:0] IDX_FAULT_C = 6'h03;
  localparam logic [5:0] IDX_MAIN_CFG = 6'h09;
  localparam logic [5:0] IDX_CLK_STAT = 6'h10;

  // field positions
  localparam int FA_RES_ERR_BIT = 4;
  localparam int FA_WDT_ERR_BIT = 5;
  localparam int FC_HIGH_BIT = 7;
  localparam int FC_LOW_BIT = 6;
  localparam int CFG_FAULT_MODE_BIT = 2;

  // reset values
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // resistor bands: codes 0..6 valid, anything above is out of range
  localparam int BAND_W = 4;
  localparam int BAND_NUM = 7;

  // control clock rate
  localparam int CLK_KHZ = 100000;

  // strap settle: two synchroniser stages plus one
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // hiccup wait period default, in control clock cycles
  localparam int HICCUP_CYCLES_DEF = 1000000;

  typedef enum logic [1:0] {ROLE_ALONE, ROLE_MASTER, ROLE_SLAVE} scg_role_e;
  typedef enum logic [1:0] {PR_RUN, PR_WAIT, PR_LATCH} scg_prot_e;

  // lower edge of each sync band in kHz; entry 7 closes the last band
  function automatic int band_edge_khz(input int i);
    case (i)
      0: band_edge_khz = 450;
      1: band_edge_khz = 600;
      2: band_edge_khz = 900;
      3: band_edge_khz = 1200;
      4: band_edge_khz = 1500;
      5: band_edge_khz = 1800;
      6: band_edge_khz = 2100;
      default: band_edge_khz = 2250;
    endcase
  endfunction

  // nominal resistor in ohms for each band
  function automatic int band_ohm(input int i);
    case (i)
      0: band_ohm = 178000;
      1: band_ohm = 120000;
      2: band_ohm = 85700;
      3: band_ohm = 66700;
      4: band_ohm = 54500;
      5: band_ohm = 46200;
      default: band_ohm = 40000;
    endcase
  endfunction

  // oscillator half period in cycles: period_ns = ohm / 90, 10 ns cycles
  function automatic logic [15:0] osc_half(input int i);
    osc_half = 16'(band_ohm(i) / 1800);
  endfunction

  // shortest allowed sync period (fastest edge), cycles
  function automatic logic [15:0] wdt_min(input int i);
    wdt_min = 16'(CLK_KHZ / band_edge_khz(i + 1));
  endfunction

  // longest allowed sync period (slowest edge), cycles
  function automatic logic [15:0] wdt_max(input int i);
    wdt_max = 16'(CLK_KHZ / band_edge_khz(i));
  endfunction

endpackage

/* File: src/scg_sync.sv */
// two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module scg_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

/* File: bench/scg_ext_osc.sv */
// external sync clock source on the far side of the sync pin
`timescale 1ns/1ps
`default_nettype none
module scg_ext_osc
(
  input wire logic en,
  input var int half_ns,
  output var logic clk_o
);
  // free-running source; a stopped source parks its pin low
  always
  begin
    if (en)
    begin
      #(half_ns) clk_o = ~clk_o;
    end
    else
    begin
      clk_o = 1'b0;
      #5;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_scg_ctrl.sv */
// self-checking bench for the switching clock generator control
`timescale 1ns/1ps
`default_nettype none
module tb_scg_ctrl;
  import scg_pkg::*;
  localparam int HIC = 50;
  localparam int LIMIT = 40000;
  localparam logic [7:0] A_FA = {IDX_FAULT_A, 2'b00};
  localparam logic [7:0] A_FC = {IDX_FAULT_C, 2'b00};
  localparam logic [7:0] A_CF = {IDX_MAIN_CFG, 2'b00};
  localparam logic [7:0] A_ST = {IDX_CLK_STAT, 2'b00};
  // oscillator half period per band, in control cycles
  localparam int HT [7] = '{98, 66, 47, 37, 30, 25, 22};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, bias = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF, band = 4'h0;
  logic [1:0] strap = 2'h0;
  logic src_en = 1'b0;
  int src_half = 370;
  logic src_clk;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic sync_out, sync_oe_n, sclk, sen, latch;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] comp;
  // pin level: the device when it drives, else the outside source
  wire logic pin = !sync_oe_n ? sync_out : src_clk;
  int failures = 0, compares = 0, cyc = 0;
  logic [15:0] lfsr = 16'h0002;
  logic [33:0] q_exp[$], q_msk[$], e, m;

  always #5 aclk = ~aclk;

  scg_ctrl #(.HICCUP_CYCLES(HIC)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bias_ready_flag(bias), .resistor_pin_a_band_code(band), .addr_strap(strap),
    .sync_in(pin), .sync_out(sync_out), .sync_oe_n(sync_oe_n),
    .switch_clk(sclk), .switch_en(sen), .main_latch_off(latch),
    .comp_band(comp));

  scg_ext_osc i_src (.en(src_en), .half_ns(src_half), .clk_o(src_clk));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt_rand(input logic [15:0] v);
    nxt_rand = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // bus answers are matched against the oldest note in the queue
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready)
    begin
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      chk({rresp, rdata} & m, e);
    end
    if (bvalid === 1'b1 && bready)
    begin
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      chk(34'(bresp), e);
    end
  end

  // hang guard; the run needs well under this many cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      failures++;
      report_and_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    q_exp.push_back(34'(r));
    q_msk.push_back(34'h3);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && awready === 1'b1)
      begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1)
      begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] x,
                    input logic [33:0] k);
    q_exp.push_back(x & k);
    q_msk.push_back(k);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // strap only settles through a reset, so each role starts here
  task automatic rst(input logic [1:0] s);
    aresetn <= 1'b0;
    strap <= s;
    bias <= 1'b0;
    src_en <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask

  task automatic up(input logic [3:0] b);
    band <= b;
    @(posedge aclk);
    bias <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask

  // second run length of the watched clock, in control cycles
  task automatic half(input bit w, output int n);
    logic s0;
    repeat (2)
    begin
      s0 = w ? pin : sclk;
      n = 0;
      while ((w ? pin : sclk) === s0 && n < 500)
      begin
        @(posedge aclk);
        n++;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [3:0] b;
    int n;
    rst(2'h0);
    rd(A_ST, 34'h0, 34'h3FFFFFE00);
    rd(A_FA, 34'(FAULT_RESET), 34'h3FFFFFFFF);
    rd(A_CF, 34'(CFG_RESET), 34'h3FFFFFFFF);
    rd(8'h3C, {2'b10, 32'h0}, 34'h3FFFFFFFF);
    wr(8'h3C, 32'h0, 2'b10);
    // alone role on a random valid band
    lfsr = nxt_rand(lfsr);
    b = 4'(lfsr % 7);
    up(b);
    chk(34'(comp), 34'(b));
    chk(34'(sync_oe_n), 34'h1);
    chk(34'(sync_out), 34'h0);
    half(1'b0, n);
    chk(34'(n), 34'(HT[b]));
    band <= b ^ 4'h1;
    repeat (4) @(posedge aclk);
    chk(34'(comp), 34'(b));
    rd(A_FA, 34'h0, 34'h30);
    wr(A_CF, {lfsr, lfsr}, 2'b00);
    rd(A_CF, 34'({lfsr, lfsr}), 34'h4);
    // out-of-range band sets the error and blocks switching
    rst(2'h0);
    up(4'h7);
    rd(A_FA, 34'h10, 34'h10);
    chk(34'(sen), 34'h0);
    wr(A_FA, 32'h10, 2'b00);
    rd(A_FA, 34'h0, 34'h10);
    // master drives its oscillator out on the pin
    rst(2'h1);
    up(4'h0);
    chk(34'(sync_oe_n), 34'h0);
    half(1'b1, n);
    chk(34'(n), 34'(HT[0]));
    rd(A_ST, 34'h200, 34'h600);
    // slave on rising edge with a clean source
    rst(2'h2);
    src_half <= 370;
    src_en <= 1'b1;
    up(4'h3);
    repeat (3000) @(posedge aclk);
    rd(A_FA, 34'h0, 34'h30);
    chk(34'(sync_oe_n), 34'h1);
    chk(34'(sen), 34'h1);
    half(1'b0, n);
    chk(34'(n >= 37 && n <= 38), 34'h1);
    rd(A_ST, 34'h400, 34'hE00);
    // falling edge slave, too fast, hiccup retries
    rst(2'h3);
    src_half <= 40;
    src_en <= 1'b1;
    up(4'h3);
    repeat (300) @(posedge aclk);
    rd(A_FA, 34'h20, 34'h20);
    rd(A_FC, 34'h80, 34'hC0);
    rd(A_ST, 34'hC00, 34'hE00);
    n = 0;
    repeat (100)
    begin
      @(posedge aclk);
      n += int'(sen === 1'b0);
    end
    chk(34'(n >= HIC), 34'h1);
    src_half <= 370;
    repeat (2000) @(posedge aclk);
    chk(34'(sen), 34'h1);
    // too slow with latch mode set: no retry
    rst(2'h2);
    up(4'h3);
    wr(A_CF, 32'h4, 2'b00);
    src_half <= 1000;
    src_en <= 1'b1;
    n = 0;
    while (latch !== 1'b1 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    chk(34'(latch), 34'h1);
    rd(A_FC, 34'h40, 34'hC0);
    src_half <= 370;
    repeat (2000) @(posedge aclk);
    chk(34'({latch, sen}), 34'h2);
    report_and_stop;
  end
endmodule
`default_nettype wire
